// ### io_xlate_pkg.sv
`default_nettype none
package io_xlate_pkg;

	// ---------------------------------------------------------------
	// direct-store addressing
	// ---------------------------------------------------------------
	localparam int EA_LOW_W  = 28;
	localparam int EXT_W     = 4;
	localparam int IO_ADDR_W = 32;
	localparam int SEG_COUNT = 16;
	localparam int SEG_MB    = 256;
	localparam logic [EA_LOW_W-1:0] BEAT_STEP = 28'h0000004;

	// ---------------------------------------------------------------
	// control registers in this unit's space
	// ---------------------------------------------------------------
	localparam logic [31:0] OFF_TBL_HI   = 32'h00000000;
	localparam logic [31:0] OFF_TBL_LO   = 32'h00000004;
	localparam logic [31:0] OFF_MAX_ENT  = 32'h00000008;
	localparam logic [31:0] REG_RESET    = 32'h00000000;
	localparam logic [31:0] RD_HARMLESS  = 32'h00000000;
	localparam int          START_W      = 12;
	localparam int          LO_START_LSB = 20;
	localparam int          SIZE_W       = 3;
	localparam int          LO_RSV_W     = 17;

	// ---------------------------------------------------------------
	// translation entries
	// ---------------------------------------------------------------
	localparam int PAGE_BITS = 12;
	localparam int IDX_W     = 20;
	localparam int SPEC_W    = 12;
	localparam int RA_W      = 64;
	localparam int ENT_W     = 64;
	localparam int DW_BITS   = 3;
	localparam int TBYTES_W  = 24;
	localparam logic [20:0] MIN_ENTRIES = 21'h002000;

	typedef enum logic {P_IDLE = 1'b0, P_BEAT = 1'b1} p_state_e;
	typedef enum logic {D_IDLE = 1'b0, D_FETCH = 1'b1} d_state_e;
	typedef enum logic {S_IDLE = 1'b0, S_FLUSH = 1'b1} s_state_e;

	// odd parity per byte, so all-zero harmless data still carries good parity
	function automatic logic [3:0] odd_par(input logic [31:0] d);
		logic [3:0] p;
		for (int i = 0; i < 4; i++) begin
			p[i] = ~^d[8*i +: 8];
		end
		return p;
	endfunction : odd_par

endpackage : io_xlate_pkg
`default_nettype wire

// ### io_xlate_line.sv
`timescale 1ns/1ps
`default_nettype none
module io_xlate_line
	import io_xlate_pkg::*;
#(
	parameter int TAG_W = 20,
	parameter int DAT_W = 64
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             fill,
	input  wire logic [TAG_W-1:0] fill_tag,
	input  wire logic [DAT_W-1:0] fill_ent,
	input  wire logic             inval,
	output logic                  valid,
	output logic [TAG_W-1:0]      tag,
	output logic [DAT_W-1:0]      ent
);

	typedef struct packed {
		logic             valid;
		logic [TAG_W-1:0] tag;
		logic [DAT_W-1:0] ent;
	} line_s;

	line_s line_reg;
	line_s line_next;

	always_comb begin
		line_next = line_reg;
		if (fill) begin
			line_next.valid = 1'b1;
			line_next.tag   = fill_tag;
			line_next.ent   = fill_ent;
		end
		// invalidation wins: a stale copy must never survive a coherence hit
		if (inval) begin
			line_next.valid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			line_reg <= '0;
		end else begin
			line_reg <= line_next;
		end
	end

	assign valid = line_reg.valid;
	assign tag   = line_reg.tag;
	assign ent   = line_reg.ent;

endmodule : io_xlate_line
`default_nettype wire

// ### io_address_and_dma_translation.sv
// Notes on behaviour
// - io address is extent bits on top of low 28 effective-address bits
// - extent picks one of 16 256MB segments; beats never leave their segment
// - every load beat returns data, harmless zeros with good parity on errors
// - memory-mapped mode drops reserved stores and reads reserved as zero
// - direct-store mode either raises storage fault or drops/zeroes, by parameter
// - access starting in unimplemented space is unimplemented for all its beats
// - dma page index looks up an entry giving the real page
// - cached entries are invalidated when memory copies are stored
// - dma uses the entry valid when its request was accepted
// - own dma writes into the table are not snooped
// - 32-bit entries pack two per doubleword, first in upper half
// - buffered page data flushed before the cached entry is dropped
// - page number in upper entry bits, unit-specific bits lowest twelve
// - unused unit-specific entry bits are ignored as reserved
// - translation present so table base and size register present
// - upper table word exists only in wide builds, else reserved
// - wide builds keep both table words in every mode
// - table start: upper word high bits, lower word top 12 bits
// - lower word low three bits give size, 8K doubling up to 1024K
// - maximum supported entries readable by software
// - extent bits arrive already extracted from the segment descriptor
`timescale 1ns/1ps
`default_nettype none
module io_address_and_dma_translation
	import io_xlate_pkg::*;
#(
	parameter bit          WIDE            = 1'b0,
	parameter bit          DIRECT_STORE    = 1'b1,
	parameter bit          DSI_ON_RESERVED = 1'b0,
	parameter logic [2:0]  MAX_SIZE_CODE   = 3'h7,
	parameter logic [11:0] SPEC_USED_MASK  = 12'h000,
	parameter int          BEAT_W          = 3,
	parameter int          LINES           = 4
) (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic                 ds_req,
	input  wire logic                 ds_we,
	input  wire logic [EA_LOW_W-1:0]  ds_ea,
	input  wire logic [EXT_W-1:0]     ds_ext,
	input  wire logic [BEAT_W-1:0]    ds_beats,
	input  wire logic [31:0]          ds_wdata,
	output logic                      ds_busy,
	output logic [IO_ADDR_W-1:0]      io_addr,
	output logic                      rsp_valid,
	output logic [31:0]               rsp_data,
	output logic [3:0]                rsp_par,
	output logic                      rsp_dsi,
	output logic                      rsp_last,
	input  wire logic                 dma_req,
	input  wire logic [31:0]          dma_addr,
	output logic                      dma_busy,
	output logic                      dma_rsp_valid,
	output logic                      dma_rsp_err,
	output logic [RA_W-1:0]           dma_real_addr,
	output logic [SPEC_W-1:0]         dma_spec,
	output logic                      mem_rd_req,
	output logic [RA_W-1:0]           mem_rd_addr,
	input  wire logic                 mem_rd_ack,
	input  wire logic [63:0]          mem_rd_data,
	input  wire logic                 snoop_valid,
	input  wire logic [RA_W-1:0]      snoop_addr,
	output logic                      snoop_ready,
	output logic                      flush_req,
	output logic [IDX_W-1:0]          flush_idx,
	output logic                      flush_pair,
	input  wire logic                 flush_done
);

	localparam int CI = (LINES > 1) ? $clog2(LINES) : 1;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [31:0]          tbl_hi;
		logic [START_W-1:0]   tbl_start;
		logic [SIZE_W-1:0]    tbl_size;
		p_state_e             p_st;
		logic [31:0]          p_addr;
		logic [BEAT_W-1:0]    p_left;
		logic                 p_we;
		logic                 p_bad;
		logic                 p_dsi;
		logic                 ds_busy;
		logic [31:0]          io_addr;
		logic                 rsp_valid;
		logic [31:0]          rsp_data;
		logic [3:0]           rsp_par;
		logic                 rsp_dsi;
		logic                 rsp_last;
		d_state_e             d_st;
		logic [IDX_W-1:0]     d_idx;
		logic [PAGE_BITS-1:0] d_off;
		logic                 d_stale;
		logic                 dma_busy;
		logic                 mem_rd_req;
		logic [RA_W-1:0]      mem_rd_addr;
		logic                 dma_rsp_valid;
		logic                 dma_rsp_err;
		logic [RA_W-1:0]      dma_real_addr;
		logic [SPEC_W-1:0]    dma_spec;
		s_state_e             s_st;
		logic [IDX_W-1:0]     s_dw;
		logic                 snoop_ready;
		logic                 flush_req;
		logic [IDX_W-1:0]     flush_idx;
		logic                 flush_pair;
	} state_s;

	state_s st_reg;
	state_s st_next;

	logic [LINES-1:0]             l_valid;
	logic [IDX_W-1:0]             l_tag   [LINES];
	logic [ENT_W-1:0]             l_ent   [LINES];
	logic [LINES-1:0]             l_fill;
	logic [LINES-1:0]             l_inval;
	logic [LINES-1:0]             l_match;
	logic [LINES-1:0]             s_hit;
	logic                         fill_now;
	logic                         tbl_wr_now;
	logic [ENT_W-1:0]             fill_ent;
	logic [RA_W-1:0]              base;
	logic [20:0]                  lim;
	logic [TBYTES_W-1:0]          tbytes;
	logic [RA_W-1:0]              soff;
	logic                         s_in;
	logic [IDX_W-1:0]             s_dw_now;
	logic [IDX_W-1:0]             req_idx;
	logic [CI-1:0]                req_line;

	// ---------------------------------------------------------------
	// cached translation entries
	// ---------------------------------------------------------------
	for (genvar g = 0; g < LINES; g++) begin : g_line
		io_xlate_line #(
			.TAG_W (IDX_W),
			.DAT_W (ENT_W)
		) u_line (
			.clk      (clk),
			.arst_n   (arst_n),
			.fill     (l_fill[g]),
			.fill_tag (st_reg.d_idx),
			.fill_ent (fill_ent),
			.inval    (l_inval[g]),
			.valid    (l_valid[g]),
			.tag      (l_tag[g]),
			.ent      (l_ent[g])
		);
	end

	function automatic logic impl(input logic [31:0] a);
		return (a == OFF_TBL_LO) || (a == OFF_MAX_ENT) || (WIDE && (a == OFF_TBL_HI));
	endfunction : impl

	function automatic logic [IDX_W-1:0] dw_of(input logic [IDX_W-1:0] idx);
		return WIDE ? idx : {1'b0, idx[IDX_W-1:1]};
	endfunction : dw_of

	// ---------------------------------------------------------------
	// table geometry and snoop decode
	// ---------------------------------------------------------------
	assign base     = {(WIDE ? st_reg.tbl_hi : 32'h00000000), st_reg.tbl_start, 20'h00000};
	assign lim      = 21'(MIN_ENTRIES << st_reg.tbl_size);
	assign tbytes   = WIDE ? TBYTES_W'({3'h0, lim} << 3) : TBYTES_W'({3'h0, lim} << 2);
	assign soff     = snoop_addr - base;
	// only stores seen on the snoop port count; own dma writes into the table never appear there
	assign s_in     = snoop_valid && (soff[RA_W-1:TBYTES_W] == 40'h0000000000) && (soff[TBYTES_W-1:0] < tbytes);
	assign s_dw_now = soff[TBYTES_W-2:DW_BITS];
	assign req_idx  = dma_addr[31:PAGE_BITS];
	assign req_line = req_idx[CI-1:0];

	for (genvar g = 0; g < LINES; g++) begin : g_match
		assign l_match[g] = l_valid[g] && (dw_of(l_tag[g]) == st_reg.s_dw);
		assign s_hit[g]   = l_valid[g] && (dw_of(l_tag[g]) == s_dw_now);
		assign l_fill[g]  = fill_now && (st_reg.d_idx[CI-1:0] == CI'(g));
		assign l_inval[g] = tbl_wr_now || ((st_reg.s_st == S_FLUSH) && flush_done && l_match[g]);
	end

	// first entry of a doubleword sits in its upper half
	assign fill_ent = WIDE ? mem_rd_data :
		(st_reg.d_idx[0] ? {32'h00000000, mem_rd_data[31:0]} : {32'h00000000, mem_rd_data[63:32]});

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [31:0]          rd;
		logic                 hit;
		logic [ENT_W-1:0]     e;
		logic [RA_W-1:0]      foff;
		logic [EA_LOW_W-1:0]  nxt;
		rd         = RD_HARMLESS;
		hit        = 1'b0;
		e          = '0;
		foff       = '0;
		nxt        = '0;
		st_next    = st_reg;
		fill_now   = 1'b0;
		tbl_wr_now = 1'b0;
		st_next.rsp_valid     = 1'b0;
		st_next.dma_rsp_valid = 1'b0;

		// processor direct-store side
		unique case (st_reg.p_st)
			P_IDLE: begin
				st_next.ds_busy = 1'b0;
				if (ds_req) begin
					st_next.p_addr  = {ds_ext, ds_ea};
					st_next.io_addr = {ds_ext, ds_ea};
					st_next.p_bad   = !impl({ds_ext, ds_ea});
					st_next.p_dsi   = !impl({ds_ext, ds_ea}) && DIRECT_STORE && DSI_ON_RESERVED;
					st_next.p_left  = ds_beats;
					st_next.p_we    = ds_we;
					st_next.ds_busy = 1'b1;
					st_next.p_st    = P_BEAT;
				end
			end
			P_BEAT: begin
				hit = impl(st_reg.p_addr) && !st_reg.p_bad;
				if (st_reg.p_addr == OFF_TBL_HI) begin
					rd = st_reg.tbl_hi;
				end else if (st_reg.p_addr == OFF_TBL_LO) begin
					rd = {st_reg.tbl_start, {LO_RSV_W{1'b0}}, st_reg.tbl_size};
				end else begin
					rd = {11'h000, 21'(MIN_ENTRIES << MAX_SIZE_CODE)};
				end
				// reserved reads and faulted beats still return a full beat of zeros
				st_next.rsp_data  = (!st_reg.p_we && hit) ? rd : RD_HARMLESS;
				st_next.rsp_par   = odd_par(st_next.rsp_data);
				st_next.rsp_valid = 1'b1;
				st_next.rsp_dsi   = st_reg.p_dsi;
				st_next.rsp_last  = (st_reg.p_left == '0);
				st_next.io_addr   = st_reg.p_addr;
				// reserved stores are dropped: only implemented words take data
				if (st_reg.p_we && hit) begin
					if (st_reg.p_addr == OFF_TBL_HI) begin
						st_next.tbl_hi = ds_wdata;
						tbl_wr_now     = 1'b1;
					end else if (st_reg.p_addr == OFF_TBL_LO) begin
						st_next.tbl_start = ds_wdata[31:LO_START_LSB];
						st_next.tbl_size  = ds_wdata[SIZE_W-1:0];
						tbl_wr_now        = 1'b1;
					end
				end
				// segment wrap keeps the extent bits fixed across beats
				nxt = st_reg.p_addr[EA_LOW_W-1:0] + BEAT_STEP;
				st_next.p_addr = {st_reg.p_addr[31:EA_LOW_W], nxt};
				st_next.p_left = st_reg.p_left - BEAT_W'(1);
				if (st_reg.p_left == '0) begin
					st_next.ds_busy = 1'b0;
					st_next.p_st    = P_IDLE;
				end
			end
		endcase

		// dma translation side
		unique case (st_reg.d_st)
			D_IDLE: begin
				st_next.dma_busy = 1'b0;
				if (dma_req) begin
					st_next.d_idx   = req_idx;
					st_next.d_off   = dma_addr[PAGE_BITS-1:0];
					st_next.d_stale = 1'b0;
					// a pending or arriving coherence hit forces a fresh fetch
					hit = l_valid[req_line] && (l_tag[req_line] == req_idx) &&
						(st_reg.s_st == S_IDLE) && !snoop_valid;
					if ({1'b0, req_idx} >= lim) begin
						st_next.dma_rsp_valid = 1'b1;
						st_next.dma_rsp_err   = 1'b1;
						st_next.dma_real_addr = '0;
						st_next.dma_spec      = '0;
					end else if (hit) begin
						e = l_ent[req_line];
						st_next.dma_rsp_valid = 1'b1;
						st_next.dma_rsp_err   = 1'b0;
						st_next.dma_real_addr = {e[ENT_W-1:PAGE_BITS], dma_addr[PAGE_BITS-1:0]};
						st_next.dma_spec      = e[SPEC_W-1:0] & SPEC_USED_MASK;
					end else begin
						foff = WIDE ? {41'h0, req_idx, 3'h0} : {42'h0, req_idx[IDX_W-1:1], 3'h0};
						st_next.mem_rd_addr = base + foff;
						st_next.mem_rd_req  = 1'b1;
						st_next.dma_busy    = 1'b1;
						st_next.d_st        = D_FETCH;
					end
				end
			end
			D_FETCH: begin
				if (s_in && (s_dw_now == dw_of(st_reg.d_idx))) begin
					st_next.d_stale = 1'b1;
				end
				if (mem_rd_ack) begin
					// the fetched value was current at acceptance; a copy overtaken by a store is not kept
					fill_now = !st_reg.d_stale && (st_reg.s_st == S_IDLE) &&
						!(s_in && (s_dw_now == dw_of(st_reg.d_idx)));
					st_next.mem_rd_req    = 1'b0;
					st_next.dma_busy      = 1'b0;
					st_next.dma_rsp_valid = 1'b1;
					st_next.dma_rsp_err   = 1'b0;
					st_next.dma_real_addr = {fill_ent[ENT_W-1:PAGE_BITS], st_reg.d_off};
					st_next.dma_spec      = fill_ent[SPEC_W-1:0] & SPEC_USED_MASK;
					st_next.d_st          = D_IDLE;
				end
			end
		endcase

		// coherence: flush page data, then drop the entry
		unique case (st_reg.s_st)
			S_IDLE: begin
				st_next.snoop_ready = 1'b1;
				if (st_reg.snoop_ready && s_in && (s_hit != '0)) begin
					st_next.s_dw        = s_dw_now;
					st_next.flush_idx   = WIDE ? s_dw_now : {s_dw_now[IDX_W-2:0], 1'b0};
					st_next.flush_pair  = !WIDE;
					st_next.flush_req   = 1'b1;
					st_next.snoop_ready = 1'b0;
					st_next.s_st        = S_FLUSH;
				end
			end
			S_FLUSH: begin
				if (flush_done) begin
					st_next.flush_req = 1'b0;
					st_next.s_st      = S_IDLE;
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// table register powers up indeterminate for software; zero here keeps simulation clean
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ds_busy       = st_reg.ds_busy;
	assign io_addr       = st_reg.io_addr;
	assign rsp_valid     = st_reg.rsp_valid;
	assign rsp_data      = st_reg.rsp_data;
	assign rsp_par       = st_reg.rsp_par;
	assign rsp_dsi       = st_reg.rsp_dsi;
	assign rsp_last      = st_reg.rsp_last;
	assign dma_busy      = st_reg.dma_busy;
	assign dma_rsp_valid = st_reg.dma_rsp_valid;
	assign dma_rsp_err   = st_reg.dma_rsp_err;
	assign dma_real_addr = st_reg.dma_real_addr;
	assign dma_spec      = st_reg.dma_spec;
	assign mem_rd_req    = st_reg.mem_rd_req;
	assign mem_rd_addr   = st_reg.mem_rd_addr;
	assign snoop_ready   = st_reg.snoop_ready;
	assign flush_req     = st_reg.flush_req;
	assign flush_idx     = st_reg.flush_idx;
	assign flush_pair    = st_reg.flush_pair;

endmodule : io_address_and_dma_translation
`default_nettype wire

// ### io_xlate_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module io_xlate_checker
	import io_xlate_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 arst_n,
	input wire logic                 ds_req,
	input wire logic [EA_LOW_W-1:0]  ds_ea,
	input wire logic [EXT_W-1:0]     ds_ext,
	input wire logic                 ds_busy,
	input wire logic [IO_ADDR_W-1:0] io_addr,
	input wire logic                 rsp_valid,
	input wire logic [31:0]          rsp_data,
	input wire logic [3:0]           rsp_par,
	input wire logic                 rsp_dsi,
	input wire logic                 dma_req,
	input wire logic [31:0]          dma_addr,
	input wire logic                 dma_busy,
	input wire logic                 dma_rsp_valid,
	input wire logic                 dma_rsp_err,
	input wire logic [RA_W-1:0]      dma_real_addr,
	input wire logic [SPEC_W-1:0]    dma_spec,
	input wire logic                 mem_rd_req,
	input wire logic [RA_W-1:0]      mem_rd_addr,
	input wire logic                 mem_rd_ack,
	input wire logic                 snoop_ready,
	input wire logic                 flush_req,
	input wire logic                 flush_done
);
	// -----
	// helpers and checks
	// -----
	logic [11:0] off_reg;
	wire logic [3:0] seg_now = io_addr[31:28];
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) off_reg <= 12'h000;
		else if (dma_req && !dma_busy) off_reg <= dma_addr[11:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// skips the edge right after a last beat
	sequence ds_take; ds_req && !ds_busy && !$past(ds_busy); endsequence
	sequence beat_walk; ##1 ds_busy ##1 rsp_valid; endsequence
	sequence flush_end; !flush_req ##1 snoop_ready; endsequence
	seg_addr_a: assert property (ds_take |=> io_addr == {$past(ds_ext), $past(ds_ea)})
		else $error("io address wrong");
	seg_hold_a: assert property (ds_busy && $past(ds_busy) |-> $stable(seg_now))
		else $error("beat left its segment");
	beat_walk_a: assert property (ds_take |-> beat_walk)
		else $error("first beat answer late");
	beat_only_a: assert property (rsp_valid |-> $past(ds_busy))
		else $error("answer without access");
	par_good_a: assert property (rsp_valid |-> rsp_par == {~^rsp_data[31:24], ~^rsp_data[23:16],
		~^rsp_data[15:8], ~^rsp_data[7:0]})
		else $error("bad parity on answer");
	no_fault_a: assert property (rsp_valid |-> !rsp_dsi)
		else $error("fault raised in drop mode");
	dma_take_a: assert property (dma_req && !dma_busy |=> dma_rsp_valid || mem_rd_req)
		else $error("dma request ignored");
	fetch_hold_a: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
		else $error("fetch dropped or moved");
	fetch_done_a: assert property (mem_rd_req && mem_rd_ack |=> dma_rsp_valid && !mem_rd_req && !dma_busy)
		else $error("fetch not answered");
	page_off_a: assert property (dma_rsp_valid && !dma_rsp_err |-> dma_real_addr[11:0] == off_reg
		&& dma_spec == 12'h000)
		else $error("offset or spare bits wrong");
	narrow_ra_a: assert property (dma_rsp_valid |-> dma_real_addr[63:32] == 32'h00000000)
		else $error("upper real address set");
	range_err_a: assert property (dma_rsp_valid && dma_rsp_err |-> dma_real_addr == 64'h0)
		else $error("range error with address");
	flush_hold_a: assert property (flush_req && !flush_done |=> flush_req && !snoop_ready)
		else $error("flush released early");
	flush_end_a: assert property (flush_req && flush_done |=> flush_end)
		else $error("flush not closed");
endmodule : io_xlate_checker
bind io_address_and_dma_translation io_xlate_checker chk (.clk(clk), .arst_n(arst_n), .ds_req(ds_req),
	.ds_ea(ds_ea), .ds_ext(ds_ext), .ds_busy(ds_busy), .io_addr(io_addr), .rsp_valid(rsp_valid),
	.rsp_data(rsp_data), .rsp_par(rsp_par), .rsp_dsi(rsp_dsi), .dma_req(dma_req), .dma_addr(dma_addr),
	.dma_busy(dma_busy), .dma_rsp_valid(dma_rsp_valid), .dma_rsp_err(dma_rsp_err),
	.dma_real_addr(dma_real_addr), .dma_spec(dma_spec), .mem_rd_req(mem_rd_req),
	.mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .snoop_ready(snoop_ready),
	.flush_req(flush_req), .flush_done(flush_done));
`default_nettype wire

// ### sysmem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sysmem_model (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        slow,
	input  wire logic [31:0] salt,
	input  wire logic        mem_rd_req,
	input  wire logic [63:0] mem_rd_addr,
	output logic             mem_rd_ack,
	output logic [63:0]      mem_rd_data,
	input  wire logic        flush_req,
	output logic             flush_done
);
	// -----
	// table memory and flush agent
	// -----
	logic [3:0] wait_cnt;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_cnt <= 4'h0;
			mem_rd_ack <= 1'b0;
			mem_rd_data <= 64'h0;
			flush_done <= 1'b0;
		end else begin
			mem_rd_ack <= 1'b0;
			flush_done <= flush_req && !flush_done;
			if (mem_rd_req && !mem_rd_ack && wait_cnt >= (slow ? 4'h6 : 4'h0)) begin
				mem_rd_ack <= 1'b1;
				wait_cnt <= 4'h0;
				mem_rd_data <= {mem_rd_addr[31:0] ^ salt, ~(mem_rd_addr[31:0] ^ salt)};
			end else begin
				wait_cnt <= mem_rd_req ? wait_cnt + 4'h1 : 4'h0;
				// idle bus shows no stale word
				mem_rd_data <= ~mem_rd_data;
			end
		end
	end
endmodule : sysmem_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import io_xlate_pkg::*;;
	// -----
	// bench
	// -----
	logic        clk, arst_n, ds_req, ds_we, ds_busy, rsp_valid, rsp_dsi, rsp_last, slow;
	logic        dma_req, dma_busy, dma_rsp_valid, dma_rsp_err, mem_rd_req, mem_rd_ack;
	logic        snoop_valid, snoop_ready, flush_req, flush_pair, flush_done;
	logic [27:0] ds_ea;
	logic [3:0]  ds_ext, rsp_par;
	logic [2:0]  ds_beats;
	logic [31:0] ds_wdata, io_addr, rsp_data, dma_addr, tbl, salt;
	logic [63:0] dma_real_addr, mem_rd_addr, mem_rd_data, snoop_addr;
	logic [11:0] dma_spec;
	logic [19:0] flush_idx;
	int          error_cnt, samples_checked;

	io_address_and_dma_translation uut (.clk(clk), .arst_n(arst_n), .ds_req(ds_req), .ds_we(ds_we),
		.ds_ea(ds_ea), .ds_ext(ds_ext), .ds_beats(ds_beats), .ds_wdata(ds_wdata), .ds_busy(ds_busy),
		.io_addr(io_addr), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_par(rsp_par),
		.rsp_dsi(rsp_dsi), .rsp_last(rsp_last), .dma_req(dma_req), .dma_addr(dma_addr),
		.dma_busy(dma_busy), .dma_rsp_valid(dma_rsp_valid), .dma_rsp_err(dma_rsp_err),
		.dma_real_addr(dma_real_addr), .dma_spec(dma_spec), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
		.snoop_valid(snoop_valid), .snoop_addr(snoop_addr), .snoop_ready(snoop_ready),
		.flush_req(flush_req), .flush_idx(flush_idx), .flush_pair(flush_pair), .flush_done(flush_done));
	sysmem_model mem (.clk(clk), .arst_n(arst_n), .slow(slow), .salt(salt), .mem_rd_req(mem_rd_req),
		.mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data),
		.flush_req(flush_req), .flush_done(flush_done));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	function automatic logic [3:0] parity_of(input logic [31:0] d);
		return {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
	endfunction : parity_of

	// one processor access; every beat answers exp
	task automatic ds_op(input logic we, input logic [3:0] segment_extent_bits, input logic [27:0] ea,
		input logic [2:0] nb, input logic [31:0] wd, input logic [31:0] exp);
		int n;
		@(negedge clk);
		{ds_req, ds_we, ds_ext, ds_ea, ds_beats, ds_wdata} = {1'b1, we, segment_extent_bits, ea, nb, wd};
		@(negedge clk);
		ds_req = 1'b0;
		for (int k = 0; k <= nb; k++) begin
			n = 0;
			while (rsp_valid !== 1'b1 && n < 20) begin
				@(negedge clk);
				n++;
			end
			chk("rsp_valid", 1, rsp_valid);
			chk("io_addr", {segment_extent_bits, ea + 28'(4 * k)}, io_addr);
			chk("rsp_data", exp, rsp_data);
			chk("rsp_par", parity_of(exp), rsp_par);
			chk("rsp_last", k == nb, rsp_last);
			@(negedge clk);
		end
		@(negedge clk);
	endtask : ds_op

	task automatic set_tbl(input logic [11:0] st, input logic [2:0] code);
		ds_op(1'b1, 4'h0, 28'h0000004, 3'h0, {st, 17'h00000, code}, 32'h0);
		tbl = {st, 20'h00000};
	endtask : set_tbl

	// one dma translation against the table image
	task automatic dma_op(input logic [31:0] a, input logic miss, input logic err);
		logic [31:0] da, ent;
		logic [63:0] d, ma;
		logic        seen;
		int          n;
		da = tbl + {a[31:13], 3'h0};
		d = {da ^ salt, ~(da ^ salt)};
		ent = a[12] ? d[31:0] : d[63:32];
		{seen, ma, n} = '0;
		@(negedge clk);
		{dma_req, dma_addr} = {1'b1, a};
		@(negedge clk);
		dma_req = 1'b0;
		while (dma_rsp_valid !== 1'b1 && n < 30) begin
			if (mem_rd_req === 1'b1) {seen, ma} = {1'b1, mem_rd_addr};
			@(negedge clk);
			n++;
		end
		chk("dma_rsp_valid", 1, dma_rsp_valid);
		chk("fetch", miss, seen);
		if (miss) chk("mem_rd_addr", {32'h0, da}, ma);
		chk("dma_rsp_err", err, dma_rsp_err);
		chk("real", err ? 64'h0 : {32'h0, ent[31:12], a[11:0]}, dma_real_addr);
		chk("spec", 0, dma_spec);
	endtask : dma_op

	task automatic t_regs;
		ds_op(1'b0, 4'h0, 28'h0000004, 3'h0, 32'h0, 32'h0);
		ds_op(1'b0, 4'h0, 28'h0000008, 3'h0, 32'h0, 32'h00100000);
		ds_op(1'b1, 4'h0, 28'h0000004, 3'h0, 32'h800FFFFD, 32'h0);
		ds_op(1'b0, 4'h0, 28'h0000004, 3'h0, 32'h0, 32'h80000005);
		ds_op(1'b1, 4'h0, 28'h0000000, 3'h0, 32'hFFFFFFFF, 32'h0);
		ds_op(1'b0, 4'h0, 28'h0000000, 3'h0, 32'h0, 32'h0);
		ds_op(1'b1, 4'h0, 28'h0000008, 3'h0, 32'h0, 32'h0);
		ds_op(1'b0, 4'h0, 28'h0000008, 3'h0, 32'h0, 32'h00100000);
	endtask : t_regs

	task automatic t_beats;
		ds_op(1'b0, 4'h0, 28'hFFFFFFC, 3'h2, 32'h0, 32'h0);
		ds_op(1'b1, 4'h0, 28'hFFFFFFC, 3'h2, 32'h12345671, 32'h0);
		ds_op(1'b0, 4'h0, 28'h0000004, 3'h0, 32'h0, 32'h80000005);
		ds_op(1'b0, 4'h5, 28'hFFFFFF8, 3'h7, 32'h0, 32'h0);
	endtask : t_beats

	task automatic t_dma;
		int n;
		set_tbl(12'h800, 3'h0);
		dma_op(32'h00005ABC, 1'b1, 1'b0);
		dma_op(32'h00005123, 1'b0, 1'b0);
		dma_op(32'h00004010, 1'b1, 1'b0);
		@(negedge clk);
		{snoop_valid, snoop_addr, salt} = {1'b1, 64'h80000010, 32'hC3C30000};
		@(negedge clk);
		snoop_valid = 1'b0;
		chk("flush_req", 1, flush_req);
		chk("flush_idx", 4, flush_idx);
		chk("flush_pair", 1, flush_pair);
		chk("snoop_ready", 0, snoop_ready);
		n = 0;
		while (flush_req !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		chk("snoop_ready", 1, snoop_ready);
		dma_op(32'h00005ABC, 1'b1, 1'b0);
		slow = 1'b1;
		dma_op(32'h00007000, 1'b1, 1'b0);
		slow = 1'b0;
	endtask : t_dma

	task automatic t_size;
		for (int c = 0; c < 8; c++) begin
			set_tbl(12'h800, 3'(c));
			if (c < 7) dma_op((32'h2000 << c) << 12, 1'b0, 1'b1);
			dma_op((((32'h2000 << c) - 1) << 12) | 32'h0FF, 1'b1, 1'b0);
		end
	endtask : t_size

	initial begin
		{ds_req, ds_we, ds_ea, ds_ext, ds_beats, ds_wdata, dma_req, dma_addr} = '0;
		{snoop_valid, snoop_addr, slow, error_cnt, samples_checked, tbl} = '0;
		salt = 32'h5A5A0000;
		arst_n = 1'b0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		t_regs();
		t_beats();
		t_dma();
		t_size();
		tally_and_finish();
	end

	// tests need under a thousand cycles
	initial begin
		#(4000 * 25);
		error_cnt++;
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
